// File: abu_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// shared constants of the address breakpoint unit
// ----------------------------------------------------------------------------
package abu_pkg;

  // register indices, byte address is four times the index
  localparam logic [15:0] ABU_IDX_LOWPOWER_STATUS = 16'hfe00;
  localparam logic [15:0] ABU_IDX_FLAG_CLEAR_CTRL = 16'hfe03;
  localparam logic [15:0] ABU_IDX_BP_ADDR_HIGH    = 16'hfe0c;
  localparam logic [15:0] ABU_IDX_BP_ADDR_LOW     = 16'hfe0d;
  localparam logic [15:0] ABU_IDX_CONTROL_STATUS  = 16'hfe0e;
  localparam logic [15:0] ABU_IDX_IRQ_STATUS      = 16'hfe10;
  localparam logic [15:0] ABU_IDX_IRQ_MASK        = 16'hfe11;

  // bus geometry
  localparam int          ABU_ADDR_W   = 18;
  localparam int          ABU_IDX_LSB  = 2;

  // field positions
  localparam int          ABU_BIT_BREAKPOINT_ENABLE = 7;
  localparam int          ABU_BIT_BREAK_ACTIVE      = 6;
  localparam int          ABU_BIT_LOWPOWER_EXIT     = 1;
  localparam int          ABU_BIT_CLEAR_IN_BREAK    = 7;
  localparam int          ABU_BIT_IRQ_BREAK_TAKEN   = 0;
  localparam int          ABU_BIT_IRQ_LOWPOWER_EXIT = 1;
  localparam int          ABU_IRQ_W                 = 2;

  // values after reset
  localparam logic [7:0]  ABU_RST_BYTE = 8'h00;
  localparam logic [ABU_IRQ_W-1:0] ABU_RST_IRQ = 2'h0;

  // break vectors, normal and monitor mode
  localparam logic [15:0] ABU_VECTOR_NORMAL  = 16'hfffc;
  localparam logic [15:0] ABU_VECTOR_MONITOR = 16'hfefc;

  // bus answer latency, wait cycles before waitrequest drops
  localparam int          ABU_BUS_WAIT_CYCLES = 1;

  // synchroniser depth for pin inputs
  localparam int          ABU_SYNC_STAGES = 3;

endpackage
`default_nettype wire

// File: abu_address_breakpoint_unit.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RL1: address match raises break request to cpu
// RL2: return from interrupt ends break state
// RL3: break loads soft interrupt opcode and vector
// RL4: break waits for current instruction end
// RL5: match on last cycle breaks at once
// RL6: timer counters halted during break state
// RL7: watchdog disabled in break with test voltage
// RL8: comparison keeps working during wait mode
// RL9: break in stop exits and sets flag
// RL10: control bit 7 enables address match breaks
// RL11: break active bit set on address match
// RL12: writing one to break active forces break
// RL13: software clears break active before leaving
// RL14: two byte registers hold breakpoint address
// RL15: lowpower exit flag, cleared by writing zero
// RL16: software may rewind return address by one
// RL17: clear enable bit gates status clears in break
// RL18: break state exported to suppress status clearing
module abu_address_breakpoint_unit
  import abu_pkg::*;
#(
  parameter logic [7:0] SOFT_INTERRUPT_OPCODE = 8'h00  // value arbitrary, set by integration
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  // avalon-mm slave
  input  wire logic [ABU_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // cpu side
  input  wire logic [15:0]           cpu_address,
  input  wire logic                  cpu_address_valid,
  input  wire logic                  cpu_instruction_end,
  input  wire logic                  cpu_rti_executed,
  input  wire logic                  cpu_in_wait,
  input  wire logic                  cpu_in_stop,
  input  wire logic                  monitor_mode,
  input  wire logic                  test_voltage_level,
  output logic                       break_request,
  output logic                       break_take,
  output logic      [7:0]            break_opcode,
  output logic      [15:0]           break_vector,
  output logic                       lowpower_wake,
  // system side
  output logic                       break_state,
  output logic                       timer_module_halt,
  output logic                       watchdog_unit_disable,
  output logic                       status_clear_inhibit,
  output logic                       irq
);

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  logic [7:0]           bp_high_reg;
  logic [7:0]           bp_low_reg;
  logic                 breakpoint_enable_reg;
  logic                 break_active_reg;
  logic                 lowpower_exit_flag_reg;
  logic                 clear_in_break_enable_reg;
  logic [ABU_IRQ_W-1:0] irq_status_reg;
  logic [ABU_IRQ_W-1:0] irq_mask_reg;
  logic                 break_pending_reg;
  logic                 break_state_reg;
  logic                 bus_ack_reg;
  logic [31:0]          readdata_reg;
  logic [7:0]           break_opcode_reg;
  logic [15:0]          break_vector_reg;

  // --------------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------------
  logic [15:0]          bus_index;
  logic                 bus_fire_wr;
  logic                 bus_lane0;
  logic [7:0]           wr_byte;
  logic                 sel_lowpower;
  logic                 sel_flag_ctrl;
  logic                 sel_bp_high;
  logic                 sel_bp_low;
  logic                 sel_ctrl_status;
  logic                 sel_irq_status;
  logic                 sel_irq_mask;

  assign bus_index = avs_address[ABU_ADDR_W-1:ABU_IDX_LSB];
  assign bus_lane0 = avs_byteenable[0];
  assign wr_byte   = avs_writedata[7:0];

  // one wait cycle first
  // then the access completes with waitrequest low
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_reg;
  assign bus_fire_wr     = avs_write & bus_ack_reg & bus_lane0;
  assign avs_readdata    = readdata_reg;

  // address decoding
  always_comb begin
    sel_lowpower    = 1'b0;
    sel_flag_ctrl   = 1'b0;
    sel_bp_high     = 1'b0;
    sel_bp_low      = 1'b0;
    sel_ctrl_status = 1'b0;
    sel_irq_status  = 1'b0;
    sel_irq_mask    = 1'b0;
    if (bus_index == ABU_IDX_LOWPOWER_STATUS) begin
      sel_lowpower = 1'b1;
    end else if (bus_index == ABU_IDX_FLAG_CLEAR_CTRL) begin
      sel_flag_ctrl = 1'b1;
    end else if (bus_index == ABU_IDX_BP_ADDR_HIGH) begin
      sel_bp_high = 1'b1;
    end else if (bus_index == ABU_IDX_BP_ADDR_LOW) begin
      sel_bp_low = 1'b1;
    end else if (bus_index == ABU_IDX_CONTROL_STATUS) begin
      sel_ctrl_status = 1'b1;
    end else if (bus_index == ABU_IDX_IRQ_STATUS) begin
      sel_irq_status = 1'b1;
    end else if (bus_index == ABU_IDX_IRQ_MASK) begin
      sel_irq_mask = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // test voltage synchroniser
  // --------------------------------------------------------------------------
  logic [ABU_SYNC_STAGES-1:0] tst_sync_reg;
  logic                       tst_level_reg;

  // three stages
  // a change is accepted once the last two agree
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tst_sync_reg  <= '0;
      tst_level_reg <= 1'b0;
    end else begin
      tst_sync_reg <= {tst_sync_reg[ABU_SYNC_STAGES-2:0], test_voltage_level};
      if (tst_sync_reg[1] == tst_sync_reg[2]) begin
        tst_level_reg <= tst_sync_reg[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // break detection and sequencing
  // --------------------------------------------------------------------------
  logic                 address_match;
  logic                 sw_force;
  logic                 sw_clear_active;
  logic                 break_cause;
  logic                 low_power;
  logic                 take_now;

  // compare runs in every mode, wait included
  // so that a match can end wait
  assign address_match = breakpoint_enable_reg & cpu_address_valid
                       & (cpu_address == {bp_high_reg, bp_low_reg});    // RL1 RL8 RL10 RL14

  assign sw_force        = bus_fire_wr & sel_ctrl_status
                         & wr_byte[ABU_BIT_BREAK_ACTIVE];               // RL12
  assign sw_clear_active = bus_fire_wr & sel_ctrl_status
                         & ~wr_byte[ABU_BIT_BREAK_ACTIVE];
  assign break_cause     = address_match | sw_force;
  assign low_power       = cpu_in_wait | cpu_in_stop;

  // taken only at an instruction boundary, or at once in wait or stop
  // where no instruction runs; a match on the last cycle is taken directly
  assign take_now = (break_pending_reg | break_cause) & ~break_state_reg
                  & (cpu_instruction_end | low_power);                  // RL4 RL5

  // request stays up from the cause
  // until the cpu takes the break
  assign break_request = (break_pending_reg | break_cause) & ~break_state_reg; // RL1
  assign break_take    = take_now;
  assign lowpower_wake = break_request & low_power;                     // RL8 RL9

  // pending request
  // held across a multi-cycle instruction
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      break_pending_reg <= 1'b0;
    end else if (take_now) begin
      break_pending_reg <= 1'b0;
    end else if (break_cause & ~break_state_reg) begin
      break_pending_reg <= 1'b1;                                        // RL4
    end
  end

  // break state, left only by the return from interrupt
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      break_state_reg <= 1'b0;
    end else if (take_now) begin
      break_state_reg <= 1'b1;
    end else if (cpu_rti_executed) begin
      break_state_reg <= 1'b0;                                          // RL2
    end
  end

  // opcode and vector for the sequencer
  // registered at the take
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      break_opcode_reg <= ABU_RST_BYTE;
      break_vector_reg <= ABU_VECTOR_NORMAL;
    end else if (take_now) begin
      break_opcode_reg <= SOFT_INTERRUPT_OPCODE;                        // RL3
      break_vector_reg <= monitor_mode ? ABU_VECTOR_MONITOR
                                       : ABU_VECTOR_NORMAL;             // RL3
    end
  end

  assign break_opcode = break_opcode_reg;
  assign break_vector = break_vector_reg;

  // --------------------------------------------------------------------------
  // effects on other modules
  // --------------------------------------------------------------------------
  // status clears elsewhere are held off
  // unless software enables them
  assign break_state           = break_state_reg;                       // RL18
  assign timer_module_halt     = break_state_reg;                       // RL6
  assign watchdog_unit_disable = break_state_reg & tst_level_reg;       // RL7
  assign status_clear_inhibit  = break_state_reg
                               & ~clear_in_break_enable_reg;            // RL17 RL18

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  // breakpoint address bytes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bp_high_reg <= ABU_RST_BYTE;
      bp_low_reg  <= ABU_RST_BYTE;
    end else begin
      if (bus_fire_wr & sel_bp_high) begin
        bp_high_reg <= wr_byte;                                         // RL14
      end
      if (bus_fire_wr & sel_bp_low) begin
        bp_low_reg <= wr_byte;                                          // RL14
      end
    end
  end

  // match enable
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      breakpoint_enable_reg <= 1'b0;
    end else if (bus_fire_wr & sel_ctrl_status) begin
      breakpoint_enable_reg <= wr_byte[ABU_BIT_BREAKPOINT_ENABLE];      // RL10
    end
  end

  // break active: set by match or force
  // a simultaneous clear loses
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      break_active_reg <= 1'b0;
    end else if (break_cause) begin
      break_active_reg <= 1'b1;                                         // RL11 RL12
    end else if (sw_clear_active) begin
      break_active_reg <= 1'b0;                                         // RL13
    end
  end

  // lowpower exit flag
  // set when a break ends wait or stop
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lowpower_exit_flag_reg <= 1'b0;
    end else if (take_now & low_power) begin
      lowpower_exit_flag_reg <= 1'b1;                                   // RL9 RL15
    end else if (bus_fire_wr & sel_lowpower & ~wr_byte[ABU_BIT_LOWPOWER_EXIT]) begin
      lowpower_exit_flag_reg <= 1'b0;                                   // RL15
    end
  end

  // clear enable during break
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clear_in_break_enable_reg <= 1'b0;
    end else if (bus_fire_wr & sel_flag_ctrl) begin
      clear_in_break_enable_reg <= wr_byte[ABU_BIT_CLEAR_IN_BREAK];     // RL17
    end
  end

  // --------------------------------------------------------------------------
  // interrupt status and mask
  // --------------------------------------------------------------------------
  logic [ABU_IRQ_W-1:0] irq_events;
  logic [ABU_IRQ_W-1:0] irq_w1c;

  assign irq_events = {take_now & low_power, take_now};
  assign irq_w1c    = (bus_fire_wr & sel_irq_status) ? wr_byte[ABU_IRQ_W-1:0]
                                                     : ABU_RST_IRQ;

  // sticky bits
  // a new event outranks a write-one clear in the same cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_status_reg <= ABU_RST_IRQ;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_w1c) | irq_events;
    end
  end

  // mask
  // a one enables the bit onto the interrupt line
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_mask_reg <= ABU_RST_IRQ;
    end else if (bus_fire_wr & sel_irq_mask) begin
      irq_mask_reg <= wr_byte[ABU_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // --------------------------------------------------------------------------
  // bus answer
  // --------------------------------------------------------------------------
  logic [7:0]           rd_byte;

  // read mux
  // reserved and unmapped locations read zero
  always_comb begin
    rd_byte = ABU_RST_BYTE;
    if (sel_lowpower) begin
      rd_byte[ABU_BIT_LOWPOWER_EXIT] = lowpower_exit_flag_reg;
    end else if (sel_flag_ctrl) begin
      rd_byte[ABU_BIT_CLEAR_IN_BREAK] = clear_in_break_enable_reg;
    end else if (sel_bp_high) begin
      rd_byte = bp_high_reg;
    end else if (sel_bp_low) begin
      rd_byte = bp_low_reg;
    end else if (sel_ctrl_status) begin
      rd_byte[ABU_BIT_BREAKPOINT_ENABLE] = breakpoint_enable_reg;
      rd_byte[ABU_BIT_BREAK_ACTIVE]      = break_active_reg;          // RL11
    end else if (sel_irq_status) begin
      rd_byte[ABU_IRQ_W-1:0] = irq_status_reg;
    end else if (sel_irq_mask) begin
      rd_byte[ABU_IRQ_W-1:0] = irq_mask_reg;
    end
  end

  // ack toggles up for exactly the completing cycle
  // never back to back
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus_ack_reg <= 1'b0;
    end else begin
      bus_ack_reg <= (avs_read | avs_write) & ~bus_ack_reg;
    end
  end

  // read data captured in the wait cycle
  // stands through the answer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      readdata_reg <= '0;
    end else if (avs_read & ~bus_ack_reg) begin
      readdata_reg <= {24'h000000, rd_byte};
    end
  end

endmodule
`default_nettype wire

// File: abu_address_breakpoint_unit_props.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// port-level checker of the breakpoint unit
// ---------------------------------------------------------------------------
module abu_address_breakpoint_unit_props
  import abu_pkg::*;
#(
  parameter logic [7:0] SOFT_INTERRUPT_OPCODE = 8'h00
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        cpu_instruction_end,
  input  wire logic        cpu_rti_executed,
  input  wire logic        cpu_in_wait,
  input  wire logic        cpu_in_stop,
  input  wire logic        monitor_mode,
  input  wire logic        test_voltage_level,
  input  wire logic        break_request,
  input  wire logic        break_take,
  input  wire logic [7:0]  break_opcode,
  input  wire logic [15:0] break_vector,
  input  wire logic        lowpower_wake,
  input  wire logic        break_state,
  input  wire logic        timer_module_halt,
  input  wire logic        watchdog_unit_disable,
  input  wire logic        status_clear_inhibit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // a take, then the halted break state
  sequence s_take; break_take; endsequence
  sequence s_in_break; break_state && timer_module_halt; endsequence
  // request held while an instruction is mid-way
  sequence s_held; break_request && !break_state
    && !(cpu_instruction_end || cpu_in_wait || cpu_in_stop); endsequence

  property p_take_at_end; s_take |-> break_request && !break_state
    && (cpu_instruction_end || cpu_in_wait || cpu_in_stop); endproperty
  property p_enter; s_take |=> s_in_break; endproperty
  property p_vector; s_take |=> break_opcode == SOFT_INTERRUPT_OPCODE && break_vector ==
    ($past(monitor_mode) ? ABU_VECTOR_MONITOR : ABU_VECTOR_NORMAL); endproperty
  property p_pending; s_held |=> break_request; endproperty
  property p_timer; timer_module_halt == break_state; endproperty
  property p_rti; break_state && cpu_rti_executed |=> !break_state; endproperty
  property p_stay; break_state && !cpu_rti_executed |=> break_state; endproperty
  property p_wdog_on; (break_state && test_voltage_level) [*5] |-> watchdog_unit_disable;
  endproperty
  property p_wdog_only; watchdog_unit_disable |-> break_state; endproperty
  property p_inhibit; status_clear_inhibit |-> break_state; endproperty
  property p_wake; lowpower_wake == (break_request && (cpu_in_wait || cpu_in_stop));
  endproperty

  a_take_at_end: assert property (p_take_at_end)
    else $error("take mid instruction");
  a_enter: assert property (p_enter)
    else $error("no halted break after take");
  a_vector: assert property (p_vector)
    else $error("bad opcode or vector");
  a_pending: assert property (p_pending)
    else $error("pending request lost");
  a_timer: assert property (p_timer)
    else $error("timer halt wrong");
  a_rti: assert property (p_rti)
    else $error("break kept after return");
  a_stay: assert property (p_stay)
    else $error("break left without return");
  a_wdog_on: assert property (p_wdog_on)
    else $error("watchdog not held off");
  a_wdog_only: assert property (p_wdog_only)
    else $error("watchdog off outside break");
  a_inhibit: assert property (p_inhibit)
    else $error("inhibit outside break");
  a_wake: assert property (p_wake)
    else $error("wake output wrong");
endmodule

bind abu_address_breakpoint_unit abu_address_breakpoint_unit_props #(
  .SOFT_INTERRUPT_OPCODE(SOFT_INTERRUPT_OPCODE)
) u_abu_address_breakpoint_unit_props (
  .clk_sys(clk_sys), .resetn(resetn), .cpu_instruction_end(cpu_instruction_end),
  .cpu_rti_executed(cpu_rti_executed), .cpu_in_wait(cpu_in_wait), .cpu_in_stop(cpu_in_stop),
  .monitor_mode(monitor_mode), .test_voltage_level(test_voltage_level),
  .break_request(break_request), .break_take(break_take), .break_opcode(break_opcode),
  .break_vector(break_vector), .lowpower_wake(lowpower_wake), .break_state(break_state),
  .timer_module_halt(timer_module_halt), .watchdog_unit_disable(watchdog_unit_disable),
  .status_clear_inhibit(status_clear_inhibit)
);
`default_nettype wire

// File: abu_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// cpu stand-in: fetch, instruction ends, return
// ---------------------------------------------------------------------------
module abu_cpu_model
  import abu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic        rti_go,
  input  wire logic        break_state,
  input  wire logic [15:0] break_vector,
  output logic      [15:0] cpu_address,
  output logic             cpu_address_valid,
  output logic             cpu_instruction_end,
  output logic             cpu_rti_executed
);
  logic [1:0] phase_reg;
  logic       isr_reg;
  // three-cycle instructions; a stalled core shows no valid address
  assign cpu_address_valid   = run;
  assign cpu_instruction_end = run && (phase_reg == 2'h2);
  // fetch; handler starts at the vector once in break
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cpu_address <= 16'h0100;
      phase_reg <= 2'h0;
      isr_reg <= 1'b0;
      cpu_rti_executed <= 1'b0;
    end else begin
      // return only from inside the handler
      cpu_rti_executed <= rti_go && break_state;
      isr_reg <= break_state;
      if (break_state && !isr_reg) begin
        cpu_address <= break_vector;
        phase_reg <= 2'h0;
      end else if (run) begin
        phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
        if (phase_reg == 2'h2) begin
          cpu_address <= cpu_address + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: address_breakpoint_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// register-level tests of the breakpoint unit
// ---------------------------------------------------------------------------
module address_breakpoint_unit_tb;
  import abu_pkg::*;
  localparam logic [7:0] OPC = 8'h83;  // arbitrary opcode value
  localparam logic [15:0] RIDX [7] = '{16'hfe00, 16'hfe03, 16'hfe0c, 16'hfe0d,
                                       16'hfe0e, 16'hfe10, 16'hfe11};
  logic clk_sys = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [ABU_ADDR_W-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'hf;
  logic cpu_in_wait = 1'b0, cpu_in_stop = 1'b0, monitor_mode = 1'b0;
  logic test_voltage_level = 1'b0, run = 1'b0, rti_go = 1'b0;
  logic [15:0] cpu_address, break_vector;
  logic [7:0]  break_opcode, rd;
  logic avs_waitrequest, cpu_address_valid, cpu_instruction_end, cpu_rti_executed;
  logic break_request, break_take, lowpower_wake, break_state, timer_module_halt;
  logic watchdog_unit_disable, status_clear_inhibit, irq;
  int err_total = 0;
  int n_tests = 0;

  abu_address_breakpoint_unit #(.SOFT_INTERRUPT_OPCODE(OPC)) u_abu_address_breakpoint_unit (
    .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_address(cpu_address), .cpu_address_valid(cpu_address_valid),
    .cpu_instruction_end(cpu_instruction_end), .cpu_rti_executed(cpu_rti_executed),
    .cpu_in_wait(cpu_in_wait), .cpu_in_stop(cpu_in_stop), .monitor_mode(monitor_mode),
    .test_voltage_level(test_voltage_level), .break_request(break_request),
    .break_take(break_take), .break_opcode(break_opcode), .break_vector(break_vector),
    .lowpower_wake(lowpower_wake), .break_state(break_state),
    .timer_module_halt(timer_module_halt), .watchdog_unit_disable(watchdog_unit_disable),
    .status_clear_inhibit(status_clear_inhibit), .irq(irq));
  abu_cpu_model u_abu_cpu_model (
    .clk_sys(clk_sys), .resetn(resetn), .run(run), .rti_go(rti_go),
    .break_state(break_state), .break_vector(break_vector), .cpu_address(cpu_address),
    .cpu_address_valid(cpu_address_valid), .cpu_instruction_end(cpu_instruction_end),
    .cpu_rti_executed(cpu_rti_executed));

  // 250 MHz system clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     input logic [3:0] be);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);  // idle edge between requests
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hf);
    chk($sformatf("reg %h", idx), {8'h0, exp}, {8'h0, rd});
  endtask

  // bounded wait for a break state level
  task automatic wait_state(input logic v);
    for (int n = 0; n < 100 && break_state !== v; n++) @(posedge clk_sys);
    chk("break_state", {15'h0, v}, {15'h0, break_state});
  endtask

  task automatic leave_break;
    wr(16'hfe0e, 8'h00);
    rti_go <= 1'b1;
    @(posedge clk_sys);
    rti_go <= 1'b0;
    wait_state(1'b0);
  endtask

  // watchdog, run needs under 2000 cycles
  initial begin
    #20000;
    err_total++;
    tally_and_finish;
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    // reset values of every register
    foreach (RIDX[i]) rdchk(RIDX[i], 8'h00);
    chk("vector", ABU_VECTOR_NORMAL, break_vector);
    // read/write, ignored byte lane, unmapped place
    wr(16'hfe0c, 8'ha5);
    rdchk(16'hfe0c, 8'ha5);
    wr(16'hfe0d, 8'h5a);
    bus(1'b1, 16'hfe0d, 8'h33, 4'he);
    rdchk(16'hfe0d, 8'h5a);
    wr(16'hfe05, 8'hff);
    rdchk(16'hfe05, 8'h00);
    wr(16'hfe03, 8'h80);
    rdchk(16'hfe03, 8'h80);
    wr(16'hfe03, 8'h00);
    // disabled match ignored, then a real one
    wr(16'hfe0c, 8'h01);
    wr(16'hfe0d, 8'h02);
    wr(16'hfe11, 8'h03);
    run <= 1'b1;
    repeat (15) @(posedge clk_sys);
    chk("no break", 16'h0, {15'h0, break_state});
    wr(16'hfe0d, 8'h08);
    wr(16'hfe0e, 8'h80);
    wait_state(1'b1);
    chk("opcode", {8'h0, OPC}, {8'h0, break_opcode});
    chk("halt", 16'h1, {15'h0, timer_module_halt});
    chk("inhibit", 16'h1, {15'h0, status_clear_inhibit});
    chk("irq", 16'h1, {15'h0, irq});
    rdchk(16'hfe0e, 8'hc0);
    rdchk(16'hfe10, 8'h01);
    wr(16'hfe10, 8'h01);
    chk("irq clear", 16'h0, {15'h0, irq});
    leave_break;
    rdchk(16'hfe0e, 8'h00);
    // forced break, monitor mode and test voltage
    monitor_mode <= 1'b1;
    test_voltage_level <= 1'b1;
    wr(16'hfe03, 8'h80);
    wr(16'hfe0e, 8'h40);
    wait_state(1'b1);
    repeat (5) @(posedge clk_sys);
    chk("vector", ABU_VECTOR_MONITOR, break_vector);
    chk("watchdog", 16'h1, {15'h0, watchdog_unit_disable});
    chk("inhibit", 16'h0, {15'h0, status_clear_inhibit});
    leave_break;
    monitor_mode <= 1'b0;
    test_voltage_level <= 1'b0;
    run <= 1'b0;
    // forced break out of wait, then out of stop
    for (int m = 0; m < 2; m++) begin
      wr(16'hfe10, 8'h03);
      cpu_in_wait <= (m == 0);
      cpu_in_stop <= (m == 1);
      wr(16'hfe0e, 8'h40);
      wait_state(1'b1);
      rdchk(16'hfe00, 8'h02);
      rdchk(16'hfe10, 8'h03);
      wr(16'hfe00, 8'h00);
      rdchk(16'hfe00, 8'h00);
      cpu_in_wait <= 1'b0;
      cpu_in_stop <= 1'b0;
      leave_break;
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
